// ### inc/fll_pkg.sv
// constants, byte layouts and types of the tuning control core
// How it works
// R01 - requested frequency held in 15-bit buffer
// R02 - gated 15-bit counter counts prescaled tuner pulses
// R03 - compare count with buffer, steer tuning
// R04 - reference counter repeats cycle, 6.4ms or 2.56ms
// R05 - pump charge linear in deviation, counter, DAC
// R06 - loop gain steps double charge up to seven
// R07 - band correction adds up to three doublings
// R08 - current hold bits lower pump current
// R09 - lock flag set inside capture window
// R10 - AFC engaged stops digital tuning, holds lock
// R11 - leaving hold range clears AFC engage
// R12 - lock rise and fall latched as events
// R13 - host may clear AFC engage any time
// R14 - AFC polarity and gain, band doubling
// R15 - no pulses tunes up; force down tunes down
// R16 - host sets force down only for recovery
// R17 - force up tunes up at lowest gain
// R18 - both force bits: no tuning, AFC on
// R19 - upper two ports latch rising, falling edges
// R20 - host keeps AFC off when ports used
// R21 - strap level selects module address
// R22 - power-down or programmed reset restores defaults
// R23 - write: address, instruction byte, data byte
// R24 - top instruction bit loads frequency; resets ones
// R25 - acknowledge valid address only, not powered down
// R26 - event bits return high after status read
// R27 - absolute error at or below window limit stops correction
// R28 - all but the gated counter on reference clock, bus inputs synchronised
// R29 - compare once per cycle after gate closes
package fll_pkg;
	localparam real CLK_PERIOD_NS = 10.0;
	localparam real CYCLE_LONG_MS = 6.4;
	localparam real GATE_LONG_MS = 5.12;
	localparam real CYCLE_SHORT_MS = 2.56;
	localparam real GATE_SHORT_MS = 1.28;
	localparam int CYCLE_LONG = int'(CYCLE_LONG_MS * 1.0E6 / CLK_PERIOD_NS);
	localparam int GATE_LONG = int'(GATE_LONG_MS * 1.0E6 / CLK_PERIOD_NS);
	localparam int CYCLE_SHORT = int'(CYCLE_SHORT_MS * 1.0E6 / CLK_PERIOD_NS);
	localparam int GATE_SHORT = int'(GATE_SHORT_MS * 1.0E6 / CLK_PERIOD_NS);
	localparam int SETTLE_CYCLES = 64;
	localparam int PUMP_STEP_CYCLES = 8;
	localparam int PUMP_MAX_CYCLES = 256 * PUMP_STEP_CYCLES;
	localparam logic [10:0] MAG_MAX = 11'h7FF;
	localparam logic [15:0] WIN_LIM1 = 16'h0001;
	localparam logic [15:0] WIN_LIM2 = 16'h0003;
	localparam logic [15:0] HOLD_LIM1 = 16'h0007;
	localparam logic [15:0] HOLD_LIM2 = 16'h000F;
	// arbitrary upper address bits
	localparam logic [4:0] ADDR_BASE = 5'h18;
	localparam logic [7:0] CMD_TC0 = 8'h29;
	localparam logic [7:0] CMD_TC1 = 8'h2A;
	localparam logic [7:0] CMD_TC2 = 8'h2B;
	localparam logic [7:0] CMD_PORTS = 8'h2C;
	localparam logic [7:0] CMD_RESET = 8'h2F;
	localparam logic [14:0] FREQ_RESET = 15'h7FFF;
	localparam logic [3:0] PORTS_RESET = 4'hF;
	// synchroniser levels in reset: bus lines and ports released high
	localparam logic [10:0] PIN_IDLE = 11'h30F;
	typedef struct packed {
		logic       afc_engage_bit;
		logic [1:0] min_voltage_select;
		logic [1:0] afc_hold_range;
		logic [1:0] current_hold_bits;
		logic [1:0] capture_window_code;
		logic [1:0] voltage_band_gain;
		logic [1:0] afc_sens;
		logic [2:0] loop_gain_steps;
		logic       afc_polarity;
		logic       prescale_mode;
		logic       force_down_bit;
		logic       force_up_bit;
	} ctl_s;
	localparam ctl_s CTL_RESET = '0;
	typedef struct packed {
		logic       afc_engage_bit;
		logic       min_voltage_select_lo;
		logic [1:0] afc_hold_range;
		logic [1:0] current_hold_bits;
		logic [1:0] capture_window_code;
	} tc0_s;
	typedef struct packed {
		logic       min_voltage_select_hi;
		logic [1:0] voltage_band_gain;
		logic [1:0] afc_sens;
		logic [2:0] loop_gain_steps;
	} tc1_s;
	typedef struct packed {
		logic [3:0] zero;
		logic       afc_polarity;
		logic       prescale_mode;
		logic       force_down_bit;
		logic       force_up_bit;
	} tc2_s;
	typedef struct packed {
		logic       in_lock_flag;
		logic       lock_gain_event_n;
		logic       lock_loss_event_n;
		logic       freq_over;
		logic       reset_flag_n;
		logic [2:0] zero;
	} status_s;
	typedef struct packed {
		logic       up;
		logic       down;
		logic [2:0] level;
		logic [3:0] gain_shift;
		logic [1:0] current;
	} pump_charge_s;
	typedef struct packed {
		logic       on;
		logic       polarity;
		logic [1:0] sens;
		logic [1:0] gain_shift;
	} afc_ctl_s;
	typedef enum logic [2:0] {
		S_IDLE  = 3'h0,
		S_ADDR  = 3'h1,
		S_INSTR = 3'h2,
		S_DATA  = 3'h3,
		S_ACK   = 3'h4,
		S_TX    = 3'h5,
		S_TXACK = 3'h6
	} bus_state_e;
endpackage : fll_pkg

// ### core/fll_tuning_control.sv
// frequency-locked tuning control core with serial bus slave
`timescale 1ns/100ps
`default_nettype none
module fll_tuning_control #(
	parameter int CYCLE_LONG  = fll_pkg::CYCLE_LONG,
	parameter int GATE_LONG   = fll_pkg::GATE_LONG,
	parameter int CYCLE_SHORT = fll_pkg::CYCLE_SHORT,
	parameter int GATE_SHORT  = fll_pkg::GATE_SHORT
) (
	// system
	input  wire logic                   clk_sys,
	input  wire logic                   rstn,
	input  wire logic                   power_down,
	// serial bus pins
	input  wire logic                   scl_in,
	input  wire logic                   sda_in,
	output logic                        sda_out,
	output logic                        sda_en_n,
	// prescaled tuner signal, clocks the counter
	input  wire logic                   prescaled_input,
	// analog side levels and controls
	input  wire logic [1:0]             tuning_band,
	input  wire logic [1:0]             address_strap_port,
	output var fll_pkg::pump_charge_s   pump_charge,
	output var fll_pkg::afc_ctl_s       afc_ctl,
	output logic [1:0]                  min_voltage_select,
	output logic                        in_lock_flag,
	// port pins
	output logic [3:0]                  band_output,
	input  wire logic [3:0]             gp_port_in,
	output logic [3:0]                  gp_port_out,
	output logic [3:0]                  gp_port_en_n
);
	localparam int CW = 20;
	localparam int EVAL_LONG = GATE_LONG + fll_pkg::SETTLE_CYCLES;
	localparam int EVAL_SHORT = GATE_SHORT + fll_pkg::SETTLE_CYCLES;
	localparam logic [2:0] STEP_LAST = 3'(fll_pkg::PUMP_STEP_CYCLES - 1);

	if (EVAL_LONG + fll_pkg::PUMP_MAX_CYCLES >= CYCLE_LONG
		|| EVAL_SHORT + fll_pkg::PUMP_MAX_CYCLES >= CYCLE_SHORT
		|| CYCLE_LONG >= 2 ** CW || CYCLE_SHORT >= 2 ** CW
		|| fll_pkg::PUMP_STEP_CYCLES != 8) begin : g_bad_timing
		$error("cycle too short for gate, settle and pump");
	end

	// pin synchronisers
	logic [10:0] pin_m;
	logic [10:0] pin_s;
	always_ff @(posedge clk_sys) begin // see R28
		if (!rstn) begin
			pin_m <= fll_pkg::PIN_IDLE;
			pin_s <= fll_pkg::PIN_IDLE;
		end else begin
			pin_m <= {power_down, scl_in, sda_in, tuning_band, address_strap_port, gp_port_in};
			pin_s <= pin_m;
		end
	end
	wire logic       pd_s    = pin_s[10];
	wire logic       scl_s   = pin_s[9];
	wire logic       sda_s   = pin_s[8];
	wire logic [1:0] band_s  = pin_s[7:6];
	wire logic [1:0] strap_s = pin_s[5:4];
	wire logic [3:0] gp_s    = pin_s[3:0];

	logic       scl_d;
	logic       sda_d;
	logic [1:0] tp_d;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			scl_d <= fll_pkg::PIN_IDLE[9];
			sda_d <= fll_pkg::PIN_IDLE[8];
			tp_d  <= fll_pkg::PIN_IDLE[3:2];
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
			tp_d  <= gp_s[3:2];
		end
	end
	wire logic scl_rise  = scl_s & ~scl_d;
	wire logic scl_fall  = ~scl_s & scl_d;
	wire logic bus_start = scl_s & scl_d & sda_d & ~sda_s;
	wire logic bus_stop  = scl_s & scl_d & ~sda_d & sda_s;

	// serial bus slave
	fll_pkg::bus_state_e state;
	fll_pkg::bus_state_e nxt;
	logic [2:0] bitc;
	logic [7:0] sh;
	logic [7:0] instr;
	logic [7:0] wr_data;
	logic [7:0] txsh;
	logic       ack_drv;
	logic       tx_ack;
	logic       rd_idx;
	logic       wr_pulse;
	logic       rd_done;
	logic [7:0] status_byte;
	logic [7:0] port_byte;

	wire logic [7:0] rx_byte = {sh[6:0], sda_s};
	wire logic       rx_state = state == fll_pkg::S_ADDR || state == fll_pkg::S_INSTR
		|| state == fll_pkg::S_DATA;
	wire logic       addr_ok = !pd_s && rx_byte[7:3] == fll_pkg::ADDR_BASE
		&& (rx_byte[2:1] == 2'h0 || rx_byte[2:1] == strap_s); // see R21 see R25
	wire logic [7:0] tx_byte = rd_idx ? port_byte : status_byte;
	wire logic [7:0] tx_next = rd_idx ? status_byte : port_byte;
	wire logic       rd_status = rd_done & ~rd_idx;
	wire logic       rd_port = rd_done & rd_idx;

	always_ff @(posedge clk_sys) begin // see R23
		if (!rstn) begin
			state    <= fll_pkg::S_IDLE;
			nxt      <= fll_pkg::S_IDLE;
			bitc     <= '0;
			sh       <= '0;
			instr    <= '0;
			wr_data  <= '0;
			txsh     <= '0;
			ack_drv  <= 1'b0;
			tx_ack   <= 1'b0;
			rd_idx   <= 1'b0;
			wr_pulse <= 1'b0;
			rd_done  <= 1'b0;
			sda_en_n <= 1'b1;
		end else begin
			wr_pulse <= 1'b0;
			rd_done  <= 1'b0;
			if (bus_stop) begin
				state    <= fll_pkg::S_IDLE;
				sda_en_n <= 1'b1;
			end else if (bus_start) begin
				state    <= fll_pkg::S_ADDR;
				bitc     <= '0;
				ack_drv  <= 1'b0;
				sda_en_n <= 1'b1;
			end else begin
				unique case (state)
					fll_pkg::S_IDLE: begin
					end
					fll_pkg::S_ADDR, fll_pkg::S_INSTR, fll_pkg::S_DATA: begin
						if (scl_rise && rx_state) begin
							sh   <= rx_byte;
							bitc <= bitc + 3'h1;
							if (bitc == 3'h7) begin
								state   <= fll_pkg::S_ACK;
								ack_drv <= 1'b0;
								if (state == fll_pkg::S_ADDR) begin
									nxt    <= rx_byte[0] ? fll_pkg::S_TX : fll_pkg::S_INSTR;
									rd_idx <= 1'b0;
									if (!addr_ok) state <= fll_pkg::S_IDLE; // see R25
								end else if (state == fll_pkg::S_INSTR) begin
									instr <= rx_byte;
									nxt   <= fll_pkg::S_DATA;
								end else begin
									wr_pulse <= 1'b1;
									wr_data  <= rx_byte;
									nxt      <= fll_pkg::S_INSTR;
								end
							end
						end
					end
					fll_pkg::S_ACK: begin
						if (scl_fall && !ack_drv) begin
							ack_drv  <= 1'b1;
							sda_en_n <= pd_s; // see R25
						end else if (scl_fall) begin
							ack_drv  <= 1'b0;
							state    <= nxt;
							bitc     <= '0;
							txsh     <= tx_byte;
							sda_en_n <= nxt == fll_pkg::S_TX ? tx_byte[7] : 1'b1;
						end
					end
					fll_pkg::S_TX: begin
						if (scl_fall && bitc == 3'h7) begin
							state    <= fll_pkg::S_TXACK;
							sda_en_n <= 1'b1;
							rd_done  <= 1'b1;
							tx_ack   <= 1'b0;
						end else if (scl_fall) begin
							bitc     <= bitc + 3'h1;
							sda_en_n <= txsh[6];
							txsh     <= {txsh[6:0], 1'b0};
						end
					end
					fll_pkg::S_TXACK: begin
						if (scl_rise && sda_s) begin
							state <= fll_pkg::S_IDLE;
						end else if (scl_rise) begin
							tx_ack <= 1'b1;
						end else if (scl_fall && tx_ack) begin
							state    <= fll_pkg::S_TX;
							bitc     <= '0;
							rd_idx   <= ~rd_idx;
							txsh     <= tx_next;
							sda_en_n <= tx_next[7];
						end
					end
					default: state <= fll_pkg::S_IDLE;
				endcase
			end
		end
	end

	// write decode
	wire logic wr_freq  = wr_pulse & instr[7];
	wire logic wr_tc0   = wr_pulse && instr == fll_pkg::CMD_TC0;
	wire logic wr_tc1   = wr_pulse && instr == fll_pkg::CMD_TC1;
	wire logic wr_tc2   = wr_pulse && instr == fll_pkg::CMD_TC2;
	wire logic wr_ports = wr_pulse && instr == fll_pkg::CMD_PORTS;
	wire logic wr_rst   = wr_pulse && instr == fll_pkg::CMD_RESET;
	wire logic reg_rst  = !rstn || pd_s || wr_rst; // see R22
	wire fll_pkg::tc0_s tc0 = wr_data;
	wire fll_pkg::tc1_s tc1 = wr_data;
	wire fll_pkg::tc2_s tc2 = wr_data;

	// link domain: gated counter on the prescaled signal
	logic        gate;
	logic        gate_m;
	logic        gate_f;
	logic [14:0] cnt_f;
	logic [14:0] cnt_g;
	wire logic [14:0] next_cnt_f = gate_f ? cnt_f + 15'h1 : cnt_f;
	always_ff @(posedge prescaled_input) begin // see R02
		if (!rstn) begin
			gate_m <= 1'b0;
			gate_f <= 1'b0;
			cnt_f  <= '0;
			cnt_g  <= '0;
		end else begin
			gate_m <= gate;
			gate_f <= gate_m;
			cnt_f  <= next_cnt_f;
			cnt_g  <= next_cnt_f ^ {1'b0, next_cnt_f[14:1]};
		end
	end

	logic [14:0] g_m;
	logic [14:0] g_s;
	logic [14:0] cnt_b;
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			g_m <= '0;
			g_s <= '0;
		end else begin
			g_m <= cnt_g;
			g_s <= g_m;
		end
	end
	for (genvar i = 0; i < 15; i++) begin : g_gray
		assign cnt_b[i] = ^g_s[14:i];
	end

	// reference cycle
	fll_pkg::ctl_s ctl;
	logic [CW-1:0] cyc;
	logic [14:0]   start_b;
	logic [14:0]   freq;
	wire logic [CW-1:0] cyc_last = ctl.prescale_mode ? CW'(CYCLE_SHORT - 1) : CW'(CYCLE_LONG - 1);
	wire logic [CW-1:0] gate_len = ctl.prescale_mode ? CW'(GATE_SHORT) : CW'(GATE_LONG);
	wire logic [CW-1:0] eval_at = ctl.prescale_mode ? CW'(EVAL_SHORT) : CW'(EVAL_LONG);
	wire logic          eval = cyc == eval_at;
	always_ff @(posedge clk_sys) begin // see R04
		if (!rstn) begin
			cyc     <= '0;
			gate    <= 1'b0;
			start_b <= '0;
		end else begin
			cyc  <= cyc >= cyc_last ? '0 : cyc + CW'(1);
			gate <= cyc < gate_len;
			if (cyc == '0) start_b <= cnt_b;
		end
	end

	// comparison, evaluated at eval only
	wire logic [14:0] meas = cnt_b - start_b;
	wire logic [15:0] diff = {1'b0, meas} - {1'b0, freq}; // see R03
	wire logic [15:0] absd = diff[15] ? ~diff + 16'h1 : diff;
	wire logic [15:0] win_lim = ctl.capture_window_code == 2'h1 ? fll_pkg::WIN_LIM1
		: ctl.capture_window_code == 2'h2 ? fll_pkg::WIN_LIM2 : 16'h0;
	wire logic [15:0] hold_lim = ctl.afc_hold_range == 2'h1 ? fll_pkg::HOLD_LIM1
		: ctl.afc_hold_range == 2'h2 ? fll_pkg::HOLD_LIM2 : 16'h0;
	wire logic in_window = absd <= win_lim; // see R27
	wire logic in_hold = absd <= hold_lim;
	wire logic afc_keep = ctl.afc_engage_bit & in_hold; // see R10
	wire logic fu = ctl.force_up_bit;
	wire logic fd = ctl.force_down_bit;
	wire logic next_lock = afc_keep | in_window; // see R09
	wire logic tune_go = !afc_keep && !(fu && fd) && (!in_window || fu || fd); // see R18
	wire logic go_up = fd ? 1'b0 : fu ? 1'b1 : diff[15]; // see R15 see R17
	wire logic [10:0] mag = absd > {5'h0, fll_pkg::MAG_MAX} ? fll_pkg::MAG_MAX : absd[10:0];
	wire logic [10:0] mag_f = mag == '0 ? 11'h1 : mag;
	wire logic [8:0] steps = {1'b0, mag_f[10:3]} + {8'h0, mag_f[2:0] != 3'h0};
	wire logic [2:0] band_sum = {1'b0, band_s} + {1'b0, ctl.voltage_band_gain};
	wire logic [1:0] band_extra = band_sum > 3'h3 ? 2'(band_sum - 3'h3) : 2'h0; // see R07
	wire logic [3:0] pump_gain = fu && !fd ? 4'h0
		: {1'b0, ctl.loop_gain_steps} + {2'h0, band_extra}; // see R06 see R17
	wire logic [1:0] afc_gain = ctl.afc_sens == 2'h0 ? 2'h0 : band_extra; // see R14
	wire logic load = eval & tune_go;

	// control registers
	logic [3:0] gp_data;
	always_ff @(posedge clk_sys) begin
		if (reg_rst) begin
			ctl         <= fll_pkg::CTL_RESET;
			freq        <= fll_pkg::FREQ_RESET; // see R24
			band_output <= '0;
			gp_data     <= fll_pkg::PORTS_RESET;
		end else begin
			if (eval && ctl.afc_engage_bit && !in_hold) ctl.afc_engage_bit <= 1'b0; // see R11
			if (wr_freq) freq <= {instr[6:0], wr_data}; // see R01 see R24
			if (wr_tc0) begin // see R13
				ctl.afc_engage_bit         <= tc0.afc_engage_bit;
				ctl.min_voltage_select[0]  <= tc0.min_voltage_select_lo;
				ctl.afc_hold_range         <= tc0.afc_hold_range;
				ctl.current_hold_bits      <= tc0.current_hold_bits;
				ctl.capture_window_code    <= tc0.capture_window_code;
			end
			if (wr_tc1) begin
				ctl.min_voltage_select[1] <= tc1.min_voltage_select_hi;
				ctl.voltage_band_gain     <= tc1.voltage_band_gain;
				ctl.afc_sens              <= tc1.afc_sens;
				ctl.loop_gain_steps       <= tc1.loop_gain_steps;
			end
			if (wr_tc2) begin
				ctl.afc_polarity   <= tc2.afc_polarity;
				ctl.prescale_mode  <= tc2.prescale_mode;
				ctl.force_down_bit <= tc2.force_down_bit;
				ctl.force_up_bit   <= tc2.force_up_bit;
			end
			if (wr_ports) begin
				gp_data     <= wr_data[7:4];
				band_output <= wr_data[3:0];
			end
		end
	end

	// charge pump sequencer
	logic [8:0] pump_cnt;
	logic [2:0] step;
	logic [2:0] rem;
	logic       dir_up;
	wire logic [8:0] next_pump_cnt = load ? steps
		: pump_cnt != '0 && step == STEP_LAST ? pump_cnt - 9'h1 : pump_cnt;
	wire logic [2:0] next_rem = load ? mag_f[2:0] : rem;
	wire logic       next_dir = load ? go_up : dir_up;
	always_ff @(posedge clk_sys) begin // see R05
		if (reg_rst) begin
			pump_cnt    <= '0;
			step        <= '0;
			rem         <= '0;
			dir_up      <= 1'b0;
			pump_charge <= '0;
		end else begin
			pump_cnt <= next_pump_cnt;
			step     <= load ? 3'h0 : step + 3'h1;
			rem      <= next_rem;
			dir_up   <= next_dir;
			pump_charge.up   <= next_pump_cnt != '0 && next_dir;
			pump_charge.down <= next_pump_cnt != '0 && !next_dir;
			pump_charge.level <= next_pump_cnt == 9'h1 && next_rem != 3'h0
				? next_rem - 3'h1 : 3'h7;
			if (load) pump_charge.gain_shift <= pump_gain;
			pump_charge.current <= ctl.current_hold_bits; // see R08
		end
	end

	// lock flag and events
	logic       lock_gain_event_n;
	logic       lock_loss_event_n;
	logic       freq_over;
	logic       reset_flag_n;
	logic [1:0] tp_rise;
	logic [1:0] tp_fall;
	wire logic lock_rise = eval & next_lock & ~in_lock_flag;
	wire logic lock_fall = eval & ~next_lock & in_lock_flag;
	always_ff @(posedge clk_sys) begin // see R12
		if (reg_rst) begin
			in_lock_flag      <= 1'b0;
			lock_gain_event_n <= 1'b1;
			lock_loss_event_n <= 1'b1;
			freq_over         <= 1'b0;
			reset_flag_n      <= 1'b0;
		end else begin
			if (eval) in_lock_flag <= next_lock; // see R29
			if (eval) freq_over <= !diff[15] && diff != '0;
			lock_gain_event_n <= lock_rise ? 1'b0 : rd_status | lock_gain_event_n; // see R26
			lock_loss_event_n <= lock_fall ? 1'b0 : rd_status | lock_loss_event_n;
			reset_flag_n      <= rd_status | reset_flag_n;
		end
	end
	for (genvar i = 0; i < 2; i++) begin : g_trans
		always_ff @(posedge clk_sys) begin // see R19
			if (reg_rst) begin
				tp_rise[i] <= 1'b0;
				tp_fall[i] <= 1'b0;
			end else begin
				tp_rise[i] <= (gp_s[2+i] & ~tp_d[i]) | (tp_rise[i] & ~rd_port);
				tp_fall[i] <= (~gp_s[2+i] & tp_d[i]) | (tp_fall[i] & ~rd_port);
			end
		end
	end
	assign status_byte = {in_lock_flag, lock_gain_event_n, lock_loss_event_n, freq_over,
		reset_flag_n, 3'h0};
	assign port_byte = {gp_s, tp_rise[0], tp_fall[0], tp_rise[1], tp_fall[1]};

	// registered pin and analog outputs
	always_ff @(posedge clk_sys) begin // see R14 see R18
		if (reg_rst) begin
			afc_ctl            <= '0;
			min_voltage_select <= '0;
			gp_port_en_n       <= fll_pkg::PORTS_RESET;
			gp_port_out        <= '0;
			sda_out            <= 1'b0;
		end else begin
			afc_ctl.on         <= ctl.afc_engage_bit | (fu & fd);
			afc_ctl.polarity   <= ctl.afc_polarity;
			afc_ctl.sens       <= ctl.afc_sens;
			afc_ctl.gain_shift <= afc_gain;
			min_voltage_select <= ctl.min_voltage_select;
			gp_port_en_n       <= gp_data;
			gp_port_out        <= '0;
			sda_out            <= 1'b0;
		end
	end

	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rstn);

	sequence s_pump_run;
		pump_charge.up [*8];
	endsequence
	a_freq_load: assert property (wr_freq && !pd_s |=> freq == {$past(instr[6:0]), $past(wr_data)}) // see R24
		else $error("frequency buffer not loaded");
	a_cycle_wrap: assert property (cyc == cyc_last && !wr_tc2 |=> cyc == '0) // see R04
		else $error("reference cycle did not wrap");
	a_gate_span: assert property (cyc == gate_len && !wr_tc2 && !reg_rst // see R02
		|=> !gate ##1 !gate)
		else $error("gate open after its window");
	a_lock_window: assert property (eval && in_window && !reg_rst |=> in_lock_flag) // see R09
		else $error("lock flag missing inside window");
	a_afc_drop: assert property (eval && ctl.afc_engage_bit && !in_hold // see R11
		&& !wr_tc0 && !reg_rst |=> !ctl.afc_engage_bit)
		else $error("afc engage kept outside hold range");
	a_gain_event: assert property ($rose(in_lock_flag) && !reg_rst |-> !lock_gain_event_n) // see R12
		else $error("lock gain event not latched");
	a_event_clear: assert property (rd_status && !lock_rise && !reg_rst |=> lock_gain_event_n) // see R26
		else $error("event bit not released after read");
	a_force_both: assert property (fu && fd && !reg_rst |-> !load ##1 afc_ctl.on) // see R18
		else $error("tuning or afc off while both force bits set");
	a_pump_len: assert property (load && go_up && !reg_rst |=> s_pump_run) // see R05
		else $error("pump pulse shorter than one step");
	a_pd_reset: assert property (pd_s |=> freq == fll_pkg::FREQ_RESET && ctl == fll_pkg::CTL_RESET) // see R22
		else $error("defaults not restored in power-down");
	a_no_ack_pd: assert property (pd_s && state == fll_pkg::S_ADDR && bitc == 3'h7 // see R25
		&& scl_rise |=> state == fll_pkg::S_IDLE)
		else $error("address accepted in power-down");
endmodule : fll_tuning_control
`default_nettype wire

// ### tb/fll_host.sv
// serial bus master model for the tuning core
`timescale 1ns/100ps
`default_nettype none
module fll_host (
	// clock
	input  wire logic clk_sys,
	// bus pins
	input  wire logic sda_en_n,
	output logic      scl,
	output logic      sda
);
	logic drv = 1'b1;
	logic r;
	initial scl = 1'b1;
	// open drain with pull-up
	assign sda = drv & sda_en_n;
	task automatic hp;
		repeat (15) @(posedge clk_sys);
	endtask : hp
	task automatic bt(input logic b);
		hp();
		drv <= b;
		hp();
		scl <= 1'b1;
		hp();
		r = sda;
		scl <= 1'b0;
	endtask : bt
	task automatic xb(input logic [7:0] b, input logic ak, output logic [7:0] q);
		for (int i = 7; i >= 0; i--) begin
			bt(b[i]);
			q[i] = r;
		end
		bt(ak);
	endtask : xb
	task automatic go;
		drv <= 1'b0;
		hp();
		scl <= 1'b0;
	endtask : go
	task automatic sp;
		hp();
		drv <= 1'b0;
		hp();
		scl <= 1'b1;
		hp();
		drv <= 1'b1;
		hp();
	endtask : sp
	task automatic write(input logic [6:0] a, input logic [7:0] i, d, output logic ack);
		logic [7:0] q;
		go();
		xb({a, 1'b0}, 1'b1, q);
		ack = ~r;
		if (ack) begin
			xb(i, 1'b1, q);
			xb(d, 1'b1, q);
		end
		sp();
	endtask : write
	// status byte acked, port byte refused to end the frame
	task automatic read(input logic [6:0] a, output logic ack, output logic [7:0] s, p);
		go();
		xb({a, 1'b1}, 1'b1, s);
		ack = ~r;
		xb(8'hFF, 1'b0, s);
		xb(8'hFF, 1'b1, p);
		sp();
	endtask : read
endmodule : fll_host
`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench of the tuning core
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	localparam int         CYC = 2700;
	localparam logic [6:0] A0 = {fll_pkg::ADDR_BASE, 2'h0};
	logic                  clk_sys = 1'b0;
	logic                  rstn = 1'b0;
	logic                  pwr_dn = 1'b0;
	logic                  pre = 1'b0;
	logic                  pre_en = 1'b1;
	logic [1:0]            band = 2'h0;
	logic [1:0]            strap = 2'h2;
	logic [1:0]            vtm;
	logic [3:0]            gp_in = 4'hF;
	logic                  scl, sda, sda_en_n, lock, ack;
	logic [3:0]            band_out, gp_en_n;
	logic [7:0]            r8, st, pt;
	fll_pkg::pump_charge_s pump;
	fll_pkg::afc_ctl_s     afc;
	int                    miscompares = 0;
	int                    num_checks = 0;
	int                    seed = 32'h7762;
	int                    n;
	always #5 clk_sys = ~clk_sys;
	// first rising edge falls inside reset so the counter side clears
	initial #3.3 forever begin
		pre = pre_en & ~pre;
		#40;
	end
	fll_tuning_control #(.CYCLE_LONG(CYC), .GATE_LONG(500), .CYCLE_SHORT(2600),
		.GATE_SHORT(200)) dut (.clk_sys(clk_sys), .rstn(rstn), .power_down(pwr_dn),
		.scl_in(scl), .sda_in(sda), .sda_out(), .sda_en_n(sda_en_n), .prescaled_input(pre),
		.tuning_band(band), .address_strap_port(strap), .pump_charge(pump), .afc_ctl(afc),
		.min_voltage_select(vtm), .in_lock_flag(lock), .band_output(band_out),
		.gp_port_in(gp_in), .gp_port_out(), .gp_port_en_n(gp_en_n));
	fll_host h (.clk_sys(clk_sys), .sda_en_n(sda_en_n), .scl(scl), .sda(sda));
	task automatic chk(input string w, input logic [15:0] s, e);
		num_checks++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", w, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] i, d);
		h.write(A0, i, d, ack);
	endtask : wr
	task automatic cy(input int k);
		repeat (k * CYC) @(posedge clk_sys);
	endtask : cy
	// bounded wait for a pump pulse
	task automatic pw;
		n = 0;
		while ((pump.up | pump.down) !== 1'b1 && n < CYC + 8) begin
			@(posedge clk_sys);
			n++;
		end
	endtask : pw
	// extra doublings from band correction
	function automatic logic [3:0] xg(input logic [1:0] c, b);
		return (b + c > 3) ? 4'(b + c - 3) : 4'h0;
	endfunction : xg
	task automatic summarize;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : summarize
	initial begin
		#1100000;
		miscompares++;
		summarize();
	end
	initial begin
		repeat (3) @(posedge clk_sys);
		rstn <= 1'b1;
		repeat (4) @(posedge clk_sys);
		chk("sda_en_n", sda_en_n, 1'b1);
		chk("gp_en_n", gp_en_n, 4'hF);
		chk("band_out", band_out, 4'h0);
		for (int m = 0; m < 4; m++) begin
			h.write({fll_pkg::ADDR_BASE, 2'(m)}, fll_pkg::CMD_PORTS, 8'hF0, ack);
			chk("addr ack", ack, m == 0 || m == strap);
		end
		repeat (2) begin
			r8 = 8'($random(seed));
			wr(fll_pkg::CMD_PORTS, r8);
			chk("band_out", band_out, r8[3:0]);
			chk("gp_en_n", gp_en_n, r8[7:4]);
		end
		$display("test bus done");
		wr(fll_pkg::CMD_PORTS, 8'hF0);
		wr(fll_pkg::CMD_TC0, 8'h22);
		wr(8'h80, 8'h3E);
		cy(2);
		chk("lock", lock, 1'b1);
		pw();
		chk("pump idle", {pump.up, pump.down}, 2'h0);
		h.read(A0, ack, st, pt);
		chk("gain evt", st[6], 1'b0);
		gp_in[2] <= 1'b0;
		repeat (10) @(posedge clk_sys);
		gp_in[2] <= 1'b1;
		repeat (10) @(posedge clk_sys);
		h.read(A0, ack, st, pt);
		chk("gain evt", st[6], 1'b1);
		chk("port evt", pt[3:0], 4'hC);
		wr(fll_pkg::CMD_TC0, 8'hA2);
		cy(1);
		chk("afc on", {afc.on, lock}, 2'h3);
		wr(fll_pkg::CMD_TC0, 8'h22);
		chk("afc off", afc.on, 1'b0);
		wr(fll_pkg::CMD_TC0, 8'hA2);
		wr(8'hFF, 8'hFF);
		cy(2);
		chk("afc drop", {afc.on, lock}, 2'h0);
		h.read(A0, ack, st, pt);
		chk("loss evt", st[5], 1'b0);
		pw();
		chk("pump dir", {pump.up, pump.down}, 2'h2);
		$display("test lock done");
		wr(fll_pkg::CMD_TC1, 8'h85);
		chk("min_voltage_select", vtm, 2'h2);
		for (int f = 1; f < 4; f++) begin
			wr(fll_pkg::CMD_TC2, 8'(f));
			cy(1);
			pw();
			chk("force", {afc.on, pump.up, pump.down}, {f == 3, f == 1, f == 2});
			if (f == 1) begin
				chk("force gain", pump.gain_shift, 4'h0);
				chk("step level", pump.level, 3'h7);
			end
		end
		wr(fll_pkg::CMD_TC2, 8'h00);
		wr(8'h80, 8'h3E);
		pre_en <= 1'b0;
		for (int c = 0; c < 4; c++) begin
			band <= 2'($random(seed));
			wr(fll_pkg::CMD_TC1, {1'b0, 2'(c), 5'h05});
			cy(1);
			pw();
			chk("no pulse", {pump.up, pump.down, pump.current}, 4'h8);
			chk("gain", pump.gain_shift, 4'h5 + xg(2'(c), band));
		end
		pre_en <= 1'b1;
		wr(fll_pkg::CMD_TC2, 8'h04);
		wr(8'h80, 8'h19);
		cy(2);
		chk("short lock", lock, 1'b1);
		$display("test tune done");
		wr(fll_pkg::CMD_PORTS, 8'h5A);
		wr(fll_pkg::CMD_RESET, 8'h00);
		chk("rst band", {band_out, gp_en_n}, 8'h0F);
		h.read(A0, ack, st, pt);
		chk("rst flag", st[3], 1'b0);
		wr(fll_pkg::CMD_PORTS, 8'h5A);
		pwr_dn <= 1'b1;
		repeat (5) @(posedge clk_sys);
		h.write(A0, fll_pkg::CMD_PORTS, 8'h00, ack);
		chk("pd ack", {ack, gp_en_n}, 5'h0F);
		pwr_dn <= 1'b0;
		$display("test reset done");
		summarize();
	end
endmodule : tb_top
`default_nettype wire
